//--- verilog/pdmm_map.sv
// Program and data memory address map of the 8-bit core
`timescale 1ns/100ps
module pdmm_map (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  // Program counter control, and the return literal loaded into the accumulator
  input  wire pdmm_pkg::pdmm_pcop_t i_pc_op,
  input  wire logic [7:0]  i_branch_offset,
  input  wire logic        i_return_with_literal,
  input  wire logic [7:0]  i_return_with_literal_literal,
  // Program memory fetch and table read
  output logic [11:0]      o_prog_addr,
  input  wire logic [13:0] i_prog_word,
  input  wire logic        i_ptr_prog_sel,
  output logic [13:0]      o_prog_data,
  // Data access
  input  wire logic        i_data_req,
  input  wire logic        i_data_we,
  input  wire logic        i_indirect,
  input  wire logic [6:0]  i_dir_field,
  input  wire logic [7:0]  i_wdata,
  input  wire logic [7:0]  i_sfr_rdata,
  output logic [7:0]       o_rdata,
  output logic             o_rvalid,
  output logic [8:0]       o_data_addr,
  output logic             o_sfr_sel,
  output logic             o_core_sel,
  // Core state
  output logic [12:0]      o_pc,
  output logic [7:0]       o_accum,
  output logic [7:0]       o_status,
  output logic [7:0]       o_pointer
);
  typedef struct packed {
    logic [12:0] pc;
    logic [7:0]  accum;
    logic [7:0]  status;
    logic [7:0]  pointer;
    logic [7:0]  program_counter_latch_high;
    logic [1:0]  rsel;
    logic        rvalid;
    logic [13:0] pdata;
    logic [7:0]  rdata;
  } pdmm_state_t;

  pdmm_state_t st_reg;
  pdmm_state_t st_next;
  pdmm_mem_if  mem ();

  pdmm_ram u_ram (
    .i_clock (i_clock),
    .port    (mem.mem)
  );

  function automatic logic is_gpr(input logic [8:0] a);
    is_gpr = (a >= pdmm_pkg::GPR0_LO && a <= pdmm_pkg::GPR0_HI) ||
             (a >= pdmm_pkg::GPR1_LO && a <= pdmm_pkg::GPR1_HI) ||
             (a >= pdmm_pkg::GPR2_LO && a <= pdmm_pkg::GPR2_HI) ||
             (a >= pdmm_pkg::GPR3_LO && a <= pdmm_pkg::GPR3_HI);
  endfunction

  function automatic logic is_core(input logic [6:0] o);
    is_core = (o == pdmm_pkg::CORE_INDIRECT_DATA_PORT) || (o == pdmm_pkg::CORE_PCL) ||
              (o == pdmm_pkg::CORE_STATUS) || (o == pdmm_pkg::CORE_PTR) ||
              (o == pdmm_pkg::CORE_PCLH) || (o == pdmm_pkg::CORE_INTC);
  endfunction

  logic [8:0] daddr;
  logic [6:0] offs;
  logic       special_function_registers;
  logic       core;
  logic       general_purpose_ram;
  logic [12:0] pc_inc;

  always_comb begin
    if (i_indirect) begin
      daddr = {st_reg.status[pdmm_pkg::STAT_IBANK], st_reg.pointer};
    end else begin
      daddr = {st_reg.status[pdmm_pkg::STAT_BANK1:pdmm_pkg::STAT_BANK0],
               i_dir_field};
    end
    offs = daddr[6:0];
    special_function_registers  = offs < pdmm_pkg::SFR_LIMIT;
    core = is_core(offs);
    general_purpose_ram  = is_gpr(daddr);
    pc_inc = st_reg.pc + 13'h0001;
  end

  // Every instruction is a single word, so sequential fetch steps by one
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = i_data_req && !i_data_we;
    unique case (i_pc_op)
      pdmm_pkg::PDMM_PC_HOLD:   st_next.pc = st_reg.pc;
      pdmm_pkg::PDMM_PC_NEXT:   st_next.pc = pc_inc;
      pdmm_pkg::PDMM_PC_IRQ:    st_next.pc = pdmm_pkg::IRQ_VECTOR;
      pdmm_pkg::PDMM_PC_BRANCH: st_next.pc = pc_inc + {5'h00, i_branch_offset};
    endcase
    if (i_return_with_literal) begin
      st_next.accum = i_return_with_literal_literal;
    end
    st_next.rsel = 2'b00;
    if (i_data_req) begin
      if (core) begin
        st_next.rsel = 2'b01;
      end else if (special_function_registers) begin
        st_next.rsel = 2'b10;
      end else if (general_purpose_ram) begin
        st_next.rsel = 2'b11;
      end
    end
    st_next.rdata = 8'h00;
    if (i_data_req && !i_data_we && (core || special_function_registers)) begin
      unique case (offs)
        pdmm_pkg::CORE_PCL:    st_next.rdata = st_reg.pc[7:0];
        pdmm_pkg::CORE_STATUS: st_next.rdata = st_reg.status;
        pdmm_pkg::CORE_PTR:    st_next.rdata = st_reg.pointer;
        pdmm_pkg::CORE_PCLH:   st_next.rdata = st_reg.program_counter_latch_high;
        default:               st_next.rdata = i_sfr_rdata;
      endcase
    end
    // STATUS, pointer and PCLH core registers are written in any bank; the value comes from i_wdata
    if (i_data_req && i_data_we && core) begin
      unique case (offs)
        // Time-out and power-down flags are read-only, so a write keeps them
        pdmm_pkg::CORE_STATUS: st_next.status = {i_wdata[7:5], st_reg.status[4:3], i_wdata[2:0]};
        pdmm_pkg::CORE_PTR:    st_next.pointer = i_wdata;
        pdmm_pkg::CORE_PCLH:   st_next.program_counter_latch_high = i_wdata;
        default:               st_next.status = st_reg.status;
      endcase
    end
    if (i_data_req && !i_data_we) begin
      st_next.accum = (general_purpose_ram || core || special_function_registers) ? st_next.accum : 8'h00;
    end
    if (i_ptr_prog_sel) begin
      st_next.pdata = i_prog_word;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '{pc: pdmm_pkg::RESET_VECTOR, status: pdmm_pkg::STATUS_RST,
                  default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign mem.we    = i_data_req && i_data_we && general_purpose_ram && !special_function_registers;
  assign mem.addr  = daddr;
  assign mem.wdata = i_wdata;

  // Upper program counter bit is dropped so high fetches wrap
  assign o_prog_addr = i_ptr_prog_sel ? {st_reg.program_counter_latch_high[3:0], st_reg.pointer}
                                      : st_reg.pc[11:0];
  assign o_prog_data = st_reg.pdata;
  always_comb begin
    unique case (st_reg.rsel)
      2'b00: o_rdata = 8'h00;
      2'b11: o_rdata = mem.rdata;
      default: o_rdata = st_reg.rdata;
    endcase
  end
  assign o_rvalid    = st_reg.rvalid;
  assign o_data_addr = daddr;
  assign o_sfr_sel   = i_data_req && special_function_registers;
  assign o_core_sel  = i_data_req && core;
  assign o_pc        = st_reg.pc;
  assign o_accum     = st_reg.accum;
  assign o_status    = st_reg.status;
  assign o_pointer   = st_reg.pointer;

  reset_pc_a: assert property (@(posedge i_clock)
    $rose(i_rstn) |-> o_pc == 13'h0000) else $error("pc not zero after reset");
  irq_vec_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_pc_op == pdmm_pkg::PDMM_PC_IRQ |=> o_pc == 13'h0004) else $error("bad irq vector");
  wrap_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    !i_ptr_prog_sel |-> o_prog_addr == o_pc[11:0]) else $error("fetch did not wrap");
  step_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_pc_op == pdmm_pkg::PDMM_PC_NEXT |=> o_pc == $past(o_pc) + 13'h0001)
    else $error("pc step not one");
  return_with_literal_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_return_with_literal |=> o_accum == $past(i_return_with_literal_literal)) else $error("literal lost");
  direct_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    !i_indirect |-> o_data_addr == {o_status[6:5], i_dir_field})
    else $error("direct address wrong");
  indirect_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_indirect |-> o_data_addr == {o_status[7], o_pointer})
    else $error("indirect address wrong");
  unmapped_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_data_req && !i_data_we && !is_gpr(o_data_addr) && o_data_addr[6:0] >= 7'h20
    |=> o_rvalid && o_rdata == 8'h00) else $error("unmapped not zero");
  sfr_low_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_sfr_sel |-> o_data_addr[6:5] == 2'b00) else $error("sfr decode wrong");
  mirror_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_data_req && i_data_we && o_data_addr[6:0] == 7'h04 |=> o_pointer == $past(i_wdata))
    else $error("pointer mirror broken");
endmodule

//--- verilog/pdmm_pkg.sv
// Package of constants and types for the program/data memory map block
package pdmm_pkg;
  localparam int PC_W        = 13;
  localparam int IWORD_W     = 14;
  localparam int PROG_AW     = 12;
  localparam int PROG_DEPTH  = 4096;
  localparam int DADDR_W     = 9;
  localparam int DIR_W       = 7;
  localparam int RAM_AW      = 9;
  localparam int RAM_DEPTH   = 512;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
  localparam logic [6:0]  SFR_LIMIT    = 7'h20;
  localparam logic [8:0]  GPR0_LO = 9'h020;
  localparam logic [8:0]  GPR0_HI = 9'h07f;
  localparam logic [8:0]  GPR1_LO = 9'h0a0;
  localparam logic [8:0]  GPR1_HI = 9'h0ef;
  localparam logic [8:0]  GPR2_LO = 9'h120;
  localparam logic [8:0]  GPR2_HI = 9'h16f;
  localparam logic [8:0]  GPR3_LO = 9'h1a0;
  localparam logic [8:0]  GPR3_HI = 9'h1ef;
  localparam logic [6:0]  CORE_INDIRECT_DATA_PORT   = 7'h00;
  localparam logic [6:0]  CORE_PCL    = 7'h02;
  localparam logic [6:0]  CORE_STATUS = 7'h03;
  localparam logic [6:0]  CORE_PTR    = 7'h04;
  localparam logic [6:0]  CORE_PCLH   = 7'h0a;
  localparam logic [6:0]  CORE_INTC   = 7'h0b;
  localparam int STAT_IBANK = 7;
  localparam int STAT_BANK1 = 6;
  localparam int STAT_BANK0 = 5;
  localparam logic [7:0] STATUS_RST = 8'h18;
  typedef enum logic [1:0] {
    PDMM_PC_HOLD,
    PDMM_PC_NEXT,
    PDMM_PC_IRQ,
    PDMM_PC_BRANCH
  } pdmm_pcop_t;
endpackage

//--- verilog/pdmm_mem_if.sv
// Interface joining the map core to its RAM module
`timescale 1ns/100ps
interface pdmm_mem_if;
  logic       we;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface

//--- verilog/pdmm_ram.sv
// Data RAM with registered read data
`timescale 1ns/100ps
module pdmm_ram (
  // Clock
  input  wire logic i_clock,
  // Access port
  pdmm_mem_if.mem   port
);
  logic [7:0] mem_reg [pdmm_pkg::RAM_DEPTH];
  logic [7:0] rdata_reg;
  always_ff @(posedge i_clock) begin
    if (port.we) begin
      mem_reg[port.addr] <= port.wdata;
    end
    rdata_reg <= mem_reg[port.addr];
  end
  assign port.rdata = rdata_reg;
endmodule

//--- tb/pdmm_far_model.sv
// Far-side model: program memory and peripheral registers seen by the map block
`timescale 1ns/100ps
module pdmm_far_model (
  // Requests from the map block
  input  wire logic [11:0] i_prog_addr,
  input  wire logic [8:0]  i_data_addr,
  // Answers
  output logic      [13:0] o_prog_word,
  output logic      [7:0]  o_sfr_rdata
);
  // Words carry their own address, so a misrouted fetch shows up
  assign o_prog_word = {i_prog_addr ^ 12'h5a3, 2'b10};
  assign o_sfr_rdata = i_data_addr[7:0] ^ 8'h3c;
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the program and data memory map
`timescale 1ns/100ps
module tb_top;
  logic                 i_clock         = 1'b0;
  logic                 i_rstn          = 1'b0;
  pdmm_pkg::pdmm_pcop_t i_pc_op         = pdmm_pkg::PDMM_PC_HOLD;
  logic [7:0]           i_branch_offset = 8'h00;
  logic [7:0]           i_return_with_literal_literal = 8'h00;
  logic [7:0]           i_wdata         = 8'h00;
  logic                 i_return_with_literal         = 1'b0;
  logic                 i_ptr_prog_sel  = 1'b0;
  logic                 i_data_req      = 1'b0;
  logic                 i_data_we       = 1'b0;
  logic                 i_indirect      = 1'b0;
  logic [6:0]           i_dir_field     = 7'h00;
  logic [13:0]          i_prog_word, o_prog_data;
  logic [7:0]           i_sfr_rdata, o_rdata, o_accum, o_status, o_pointer, rd, d, v, ptr;
  logic [11:0]          o_prog_addr;
  logic [8:0]           o_data_addr;
  logic [12:0]          o_pc, pc_exp;
  logic                 o_rvalid, o_sfr_sel, o_core_sel, indirect_bank_bit;
  logic [1:0]           rp;
  logic [6:0]           f;
  integer               n_mismatch = 0, n_checks = 0, cycles = 0, k;
  integer               seed = 32'h0000_a2d3;

  pdmm_map uut (.i_clock(i_clock), .i_rstn(i_rstn), .i_pc_op(i_pc_op),
    .i_branch_offset(i_branch_offset), .i_return_with_literal(i_return_with_literal), .i_return_with_literal_literal(i_return_with_literal_literal),
    .o_prog_addr(o_prog_addr), .i_prog_word(i_prog_word), .i_ptr_prog_sel(i_ptr_prog_sel),
    .o_prog_data(o_prog_data), .i_data_req(i_data_req), .i_data_we(i_data_we),
    .i_indirect(i_indirect), .i_dir_field(i_dir_field), .i_wdata(i_wdata),
    .i_sfr_rdata(i_sfr_rdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_data_addr(o_data_addr), .o_sfr_sel(o_sfr_sel), .o_core_sel(o_core_sel),
    .o_pc(o_pc), .o_accum(o_accum), .o_status(o_status), .o_pointer(o_pointer));
  pdmm_far_model far (.i_prog_addr(o_prog_addr), .i_data_addr(o_data_addr),
    .o_prog_word(i_prog_word), .o_sfr_rdata(i_sfr_rdata));

  always #50 i_clock = ~i_clock;

  function automatic logic is_gpr(input logic [8:0] a);
    return (a[6:0] >= 7'h20) && (a[6:0] <= ((a[8:7] == 2'b00) ? 7'h7f : 7'h6f));
  endfunction
  function automatic logic [13:0] word_of(input logic [11:0] a);
    return {a ^ 12'h5a3, 2'b10};
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask
  // One data access; inputs held over the taking edge, read data looked at in the next cycle
  task automatic acc(input logic we, input logic ind, input logic [6:0] fld, input logic [7:0] wd);
    i_data_req = 1'b1;
    i_data_we = we;
    i_indirect = ind;
    i_dir_field = fld;
    i_wdata = wd;
    #1 chk(o_data_addr, ind ? {indirect_bank_bit, ptr} : {rp, fld});
    @(posedge i_clock);
    #1 i_data_req = 1'b0;
    rd = o_rdata;
    if (!we) chk(o_rvalid, 1'b1);
    // An idle edge separates calls, so the request is never set twice in one step
    tick();
  endtask

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    ptr = 8'h00;
    indirect_bank_bit = 1'b0;
    rp = 2'b00;
    repeat (12) @(posedge i_clock);
    #1 i_rstn = 1'b1;
    chk(o_pc, pdmm_pkg::RESET_VECTOR);
    chk(o_status, 8'h18);
    pc_exp = 13'h0000;
    // Large steps push the counter past 4K, short of 8K
    for (k = 0; k < 40; k++) begin
      i_pc_op = (k % 4 == 3) ? pdmm_pkg::PDMM_PC_NEXT : pdmm_pkg::PDMM_PC_BRANCH;
      i_branch_offset = (k < 30) ? 8'hff : 8'($random(seed));
      #1 chk(o_prog_addr, pc_exp[11:0]);
      pc_exp = pc_exp + 13'h0001 + ((k % 4 == 3) ? 13'h0000 : {5'h00, i_branch_offset});
      @(posedge i_clock);
      #1 chk(o_pc, pc_exp);
    end
    i_pc_op = pdmm_pkg::PDMM_PC_IRQ;
    tick();
    i_pc_op = pdmm_pkg::PDMM_PC_HOLD;
    chk(o_pc, pdmm_pkg::IRQ_VECTOR);
    v = $random(seed);
    i_return_with_literal = 1'b1;
    i_return_with_literal_literal = v;
    tick();
    i_return_with_literal = 1'b0;
    chk(o_accum, v);
    for (k = 0; k < 64; k++) begin
      acc(1'b1, 1'b0, pdmm_pkg::CORE_STATUS, {k[2], k[1:0], 5'h00});
      indirect_bank_bit = k[2];
      rp = k[1:0];
      chk(o_status[7:3], {indirect_bank_bit, rp, 2'b11});
      f = $random(seed);
      if (f < 7'h20) f = f + 7'h20;
      d = $random(seed);
      acc(1'b1, 1'b0, f, d);
      acc(1'b0, 1'b0, f, 8'h00);
      chk(rd, is_gpr({rp, f}) ? d : 8'h00);
      v = 8'($random(seed)) | 8'h20;
      acc(1'b1, 1'b0, pdmm_pkg::CORE_PTR, v);
      ptr = v;
      chk(o_pointer, ptr);
      d = $random(seed);
      acc(1'b1, 1'b1, 7'h00, d);
      acc(1'b0, 1'b1, 7'h00, 8'h00);
      chk(rd, is_gpr({indirect_bank_bit, ptr}) ? d : 8'h00);
      acc(1'b0, 1'b0, pdmm_pkg::CORE_PTR, 8'h00);
      chk(rd, ptr);
      acc(1'b0, 1'b0, 7'h01, 8'h00);
      chk(rd, {rp[0], 7'h01} ^ 8'h3c);
    end
    v = $random(seed);
    acc(1'b1, 1'b0, pdmm_pkg::CORE_PCLH, v);
    i_ptr_prog_sel = 1'b1;
    #1 chk(o_prog_addr, {v[3:0], ptr});
    @(posedge i_clock);
    #1 i_ptr_prog_sel = 1'b0;
    chk(o_prog_data, word_of({v[3:0], ptr}));
    close_out();
  end
endmodule
